// ### core/swe_cfg_pkg.sv
package swe_cfg_pkg;
    // bus geometry
    localparam int DATA_W = 32;
    localparam int N_PORTS = 3;
    // register indexes, byte address is four times the index
    localparam logic [13:0] IDX_GLOBAL_INGRESS = 14'h1840;
    localparam logic [13:0] IDX_PORT_INGRESS   = 14'h1841;
    localparam logic [13:0] IDX_ADMIT_TAGGED   = 14'h1842;
    localparam logic [13:0] IDX_STP_STATE      = 14'h1843;
    localparam logic [13:0] IDX_PRI_QUEUE      = 14'h1845;
    localparam logic [13:0] IDX_MIRROR         = 14'h1846;
    localparam logic [13:0] IDX_TAG_DEST       = 14'h1847;
    localparam logic [13:0] IDX_IRQ_STATUS     = 14'h1880;
    localparam logic [13:0] IDX_IRQ_MASK       = 14'h1881;
    // writable bit masks, every other bit reads zero
    localparam logic [31:0] MASK_GLOBAL  = 32'h0000_0001;
    localparam logic [31:0] MASK_PORT    = 32'h0000_003F;
    localparam logic [31:0] MASK_ADMIT   = 32'h0000_0007;
    localparam logic [31:0] MASK_STP     = 32'h0000_003F;
    localparam logic [31:0] MASK_PRIQ    = 32'h0000_FFFF;
    localparam logic [31:0] MASK_MIRROR  = 32'h0000_01FF;
    localparam logic [31:0] MASK_TAGDEST = 32'h0000_003F;
    localparam logic [31:0] MASK_IRQ     = 32'h0000_0007;
    // reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [31:0] RST_PORT = 32'h0000_0038;
    localparam logic [31:0] RST_PRIQ = 32'h0000_FA41;
    // field positions
    localparam int VLAN_EN_BIT   = 0;
    localparam int LEARN_LSB     = 3;
    localparam int MIR_TX_BIT    = 0;
    localparam int MIR_RX_BIT    = 1;
    localparam int MIR_PORT_LSB  = 2;
    localparam int MIR_SNIFF_LSB = 5;
    localparam int MIR_FILT_BIT  = 8;
    localparam int IRQ_DROP      = 0;
    localparam int IRQ_RX_MIR    = 1;
    localparam int IRQ_TX_MIR    = 2;
    localparam int IRQ_W         = 3;
    // spanning tree codes and the tag-destination code
    localparam logic [1:0] STP_FORWARD = 2'h0;
    localparam logic [1:0] STP_BLOCK   = 2'h1;
    localparam logic [1:0] STP_LEARN   = 2'h2;
    localparam logic [1:0] STP_LISTEN  = 2'h3;
    localparam logic [1:0] TAG_DEST_ON = 2'h3;
    // bus slave states
    typedef enum logic [0:0] {
        BUS_IDLE = 1'h0,
        BUS_ACK  = 1'h1
    } bus_state_t;
    // two-bit field i of a packed word
    function automatic logic [1:0] field2(input logic [31:0] v, input logic [2:0] i);
        return v[{i, 1'b0} +: 2];
    endfunction
endpackage

// ### core/event_sticky.sv
`timescale 1ns/1ps
module event_sticky
    import swe_cfg_pkg::*;
#(
    parameter int W = IRQ_W
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // events, clear and mask
    input  wire logic [W-1:0] event_i,
    input  wire logic [W-1:0] clear_i,
    input  wire logic [W-1:0] mask_i,
    // state
    output logic      [W-1:0] status_o,
    output logic              irq_o
);
    typedef struct packed {
        logic [W-1:0] status;
        logic         irq;
    } sticky_state_t;
    sticky_state_t cur;
    sticky_state_t next_cur;
    // a set in the same cycle as its clear wins, so no event is lost
    always_comb begin
        next_cur.status = (cur.status & ~clear_i) | event_i;
        next_cur.irq    = |(next_cur.status & mask_i);
    end
    // register the state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end
    assign status_o = cur.status;
    assign irq_o    = cur.irq;
endmodule

// ### core/ingress_verdict.sv
`timescale 1ns/1ps
module ingress_verdict
    import swe_cfg_pkg::*;
(
    // frame attributes
    input  wire logic [1:0] port_i,
    input  wire logic       tagged_i,
    input  wire logic       prio_tagged_i,
    input  wire logic       rule_drop_i,
    // configuration
    input  wire logic       vlan_en_i,
    input  wire logic [2:0] admit_i,
    input  wire logic [5:0] stp_i,
    input  wire logic [2:0] learn_en_i,
    input  wire logic [8:0] mirror_i,
    input  wire logic [5:0] tag_dest_i,
    // verdict
    output logic            discard_o,
    output logic            mirror_o,
    output logic            learn_o,
    output logic            tag_dest_o
);
    logic       port_ok;   // port index 3 names no port
    logic [1:0] st;        // spanning tree state of the port
    logic       untag_drop;
    always_comb begin
        port_ok    = (port_i != 2'h3);
        st         = port_ok ? field2({26'h0, stp_i}, {1'b0, port_i}) : STP_BLOCK;
        // untagged or priority-only tagged frames, gated by vlan enable
        untag_drop = vlan_en_i && port_ok && admit_i[port_i]
                     && (!tagged_i || prio_tagged_i);
        // anything but forwarding passes no data
        discard_o  = !port_ok || untag_drop || rule_drop_i || (st != STP_FORWARD);
        learn_o    = port_ok && learn_en_i[port_i]
                     && (st == STP_FORWARD || st == STP_LEARN);
        // filtered frames are mirrored only with the filtered option
        mirror_o   = port_ok && mirror_i[MIR_RX_BIT] && mirror_i[MIR_PORT_LSB + port_i]
                     && (!discard_o || mirror_i[MIR_FILT_BIT]);
        tag_dest_o = port_ok
                     && (field2({26'h0, tag_dest_i}, {1'b0, port_i}) == TAG_DEST_ON);
    end
endmodule

// ### core/switch_ingress_mirror_config.sv
// Function
// - drop untagged or priority-tagged frames on flagged ports
// - tagged-only filter works only with vlan enabled
// - two-bit spanning tree state per port
// - egress queue from two-bit class per priority
// - class table resets to 01,00,00,01,10,10,11,11
// - rx mirroring copies mirrored-port receives to sniffer
// - tx mirroring copies mirrored-port transmits to sniffer
// - mirrored ports form a free three-bit bitmap
// - filtered frames mirrored only with filtered option
// - mirrored filtered frames still count and interrupt
// - ingress type 11b enables tag-chosen destination
// - learn only when enabled and forwarding or learning
// - global vlan bit enables the tagged-only filter and tag priority; rule drops apply always
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
module switch_ingress_mirror_config
    import swe_cfg_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter int PORTS  = N_PORTS
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // wishbone classic slave
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [ADDR_W-1:0] adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    output logic                   ack_o,
    // received frame, one-cycle strobe with attributes
    input  wire logic              rx_valid_i,
    input  wire logic [1:0]        rx_port_i,
    input  wire logic              rx_tagged_i,
    input  wire logic              rx_prio_tagged_i,
    input  wire logic              rx_rule_drop_i,
    input  wire logic [2:0]        rx_tag_priority_i,
    input  wire logic [2:0]        rx_default_priority_i,
    // transmitted frame, one-cycle strobe
    input  wire logic              tx_valid_i,
    input  wire logic [1:0]        tx_port_i,
    // receive verdict, valid one cycle after the strobe
    output logic                   rx_done_o,
    output logic                   rx_discard_o,
    output logic                   rx_mirror_o,
    output logic [2:0]             rx_sniffer_o,
    output logic [1:0]             rx_queue_o,
    output logic                   rx_learn_o,
    output logic                   rx_tag_dest_o,
    output logic [2:0]             filtered_inc_o,
    // transmit mirror copy
    output logic                   tx_mirror_o,
    output logic [2:0]             tx_sniffer_o,
    // interrupt
    output logic                   irq_o
);
    // the logic is written for three ports and word indexes of 14 bits
    if (PORTS != 3 || ADDR_W < 16) begin : g_bad_param
        $error("switch config needs three ports and a 16-bit byte address");
    end

    // all state of the block but the sticky interrupt status
    typedef struct packed {
        bus_state_t  bus;
        logic        ack;
        logic [31:0] rdat;
        logic [31:0] global_ingress_config;
        logic [31:0] per_port_ingress_config;
        logic [31:0] admit_tagged_only;
        logic [31:0] spanning_tree_state;
        logic [31:0] priority_queue_map;
        logic [31:0] mirroring_control;
        logic [31:0] ingress_tag_destination_type;
        logic [31:0] irq_mask;
        logic        rx_done;
        logic        rx_discard;
        logic        rx_mirror;
        logic [2:0]  rx_sniffer;
        logic [1:0]  rx_queue;
        logic        rx_learn;
        logic        rx_tag_dest;
        logic [2:0]  filtered_inc;
        logic        tx_mirror;
        logic [2:0]  tx_sniffer;
    } cfg_state_t;

    cfg_state_t cur;       // registered state
    cfg_state_t next_cur;  // next state

    // byte-lane merge of a write into a register, reserved bits held at zero
    function automatic logic [31:0] wb_merge(
        input logic [31:0] old,
        input logic [31:0] wdat,
        input logic [3:0]  sel,
        input logic [31:0] mask
    );
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = wdat[8*b +: 8];
            end
        end
        return res & mask;
    endfunction

    // decoded bus request
    logic [13:0]      idx;        // word index of the access
    logic             take;       // a new request is accepted this cycle
    logic             wr;         // accepted request is a write
    // verdict of the received frame
    logic             v_discard;
    logic             v_mirror;
    logic             v_learn;
    logic             v_tag_dest;
    logic [2:0]       v_prio;     // priority used to pick the queue
    // interrupt wiring
    logic [IRQ_W-1:0] irq_event;
    logic [IRQ_W-1:0] irq_clear;
    logic [IRQ_W-1:0] irq_status;
    logic             irq_line;
    logic             tx_port_ok;

    // the word index drops the two byte bits of the address
    assign idx  = adr_i[15:2];
    // accept only from idle, so a held request is served once
    assign take = cyc_i && stb_i && (cur.bus == BUS_IDLE);
    assign wr   = take && we_i;

    // per-frame decision on the current configuration
    ingress_verdict u_verdict (
        .port_i        (rx_port_i),
        .tagged_i      (rx_tagged_i),
        .prio_tagged_i (rx_prio_tagged_i),
        .rule_drop_i   (rx_rule_drop_i),
        .vlan_en_i     (cur.global_ingress_config[VLAN_EN_BIT]),
        .admit_i       (cur.admit_tagged_only[2:0]),
        .stp_i         (cur.spanning_tree_state[5:0]),
        .learn_en_i    (cur.per_port_ingress_config[LEARN_LSB +: 3]),
        .mirror_i      (cur.mirroring_control[8:0]),
        .tag_dest_i    (cur.ingress_tag_destination_type[5:0]),
        .discard_o     (v_discard),
        .mirror_o      (v_mirror),
        .learn_o       (v_learn),
        .tag_dest_o    (v_tag_dest)
    );

    // events for the sticky status
    always_comb begin
        tx_port_ok = (tx_port_i != 2'h3);
        irq_event = '0;
        // a dropped frame interrupts even when it is mirrored
        irq_event[IRQ_DROP]   = rx_valid_i && v_discard;
        irq_event[IRQ_RX_MIR] = rx_valid_i && v_mirror;
        irq_event[IRQ_TX_MIR] = tx_valid_i && tx_port_ok
                                && cur.mirroring_control[MIR_TX_BIT]
                                && cur.mirroring_control[MIR_PORT_LSB + tx_port_i];
        // write one to clear, only on an accepted status write
        irq_clear = '0;
        if (wr && idx == IDX_IRQ_STATUS) begin
            irq_clear = IRQ_W'(wb_merge(RST_ZERO, dat_i, sel_i, MASK_IRQ));
        end
    end

    // sticky status, mask gating and the interrupt flop
    event_sticky #(
        .W (IRQ_W)
    ) u_sticky (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .event_i  (irq_event),
        .clear_i  (irq_clear),
        .mask_i   (cur.irq_mask[IRQ_W-1:0]),
        .status_o (irq_status),
        .irq_o    (irq_line)
    );

    // next state: bus slave, register writes and the frame verdicts
    always_comb begin
        next_cur = cur;

        // bus handshake: ack one cycle after accept, dropped the cycle after
        case (cur.bus)
            BUS_IDLE: begin
                next_cur.ack = 1'b0;
                if (take) begin
                    next_cur.bus = BUS_ACK;
                    next_cur.ack = 1'b1;
                end
            end
            BUS_ACK: begin
                next_cur.bus = BUS_IDLE;
                next_cur.ack = 1'b0;
            end
            default: begin
                next_cur.bus = BUS_IDLE;
                next_cur.ack = 1'b0;
            end
        endcase

        // read data, unmapped words read zero
        if (take) begin
            if (idx == IDX_GLOBAL_INGRESS) begin
                next_cur.rdat = cur.global_ingress_config;
            end else if (idx == IDX_PORT_INGRESS) begin
                next_cur.rdat = cur.per_port_ingress_config;
            end else if (idx == IDX_ADMIT_TAGGED) begin
                next_cur.rdat = cur.admit_tagged_only;
            end else if (idx == IDX_STP_STATE) begin
                next_cur.rdat = cur.spanning_tree_state;
            end else if (idx == IDX_PRI_QUEUE) begin
                next_cur.rdat = cur.priority_queue_map;
            end else if (idx == IDX_MIRROR) begin
                next_cur.rdat = cur.mirroring_control;
            end else if (idx == IDX_TAG_DEST) begin
                next_cur.rdat = cur.ingress_tag_destination_type;
            end else if (idx == IDX_IRQ_STATUS) begin
                next_cur.rdat = {29'h0, irq_status};
            end else if (idx == IDX_IRQ_MASK) begin
                next_cur.rdat = cur.irq_mask;
            end else begin
                next_cur.rdat = RST_ZERO;
            end
        end

        // register writes, masked so reserved bits stay zero
        if (wr) begin
            if (idx == IDX_GLOBAL_INGRESS) begin
                next_cur.global_ingress_config =
                    wb_merge(cur.global_ingress_config, dat_i, sel_i, MASK_GLOBAL);
            end else if (idx == IDX_PORT_INGRESS) begin
                next_cur.per_port_ingress_config =
                    wb_merge(cur.per_port_ingress_config, dat_i, sel_i, MASK_PORT);
            end else if (idx == IDX_ADMIT_TAGGED) begin
                next_cur.admit_tagged_only =
                    wb_merge(cur.admit_tagged_only, dat_i, sel_i, MASK_ADMIT);
            end else if (idx == IDX_STP_STATE) begin
                // host port 0 is left forwarding by software, not forced here
                next_cur.spanning_tree_state =
                    wb_merge(cur.spanning_tree_state, dat_i, sel_i, MASK_STP);
            end else if (idx == IDX_PRI_QUEUE) begin
                next_cur.priority_queue_map =
                    wb_merge(cur.priority_queue_map, dat_i, sel_i, MASK_PRIQ);
            end else if (idx == IDX_MIRROR) begin
                // several mirrored ports may be set at once
                next_cur.mirroring_control =
                    wb_merge(cur.mirroring_control, dat_i, sel_i, MASK_MIRROR);
            end else if (idx == IDX_TAG_DEST) begin
                next_cur.ingress_tag_destination_type =
                    wb_merge(cur.ingress_tag_destination_type, dat_i, sel_i, MASK_TAGDEST);
            end else if (idx == IDX_IRQ_MASK) begin
                next_cur.irq_mask = wb_merge(cur.irq_mask, dat_i, sel_i, MASK_IRQ);
            end
        end

        // the tag priority counts only with vlans enabled on a tagged frame
        if (cur.global_ingress_config[VLAN_EN_BIT] && rx_tagged_i) begin
            v_prio = rx_tag_priority_i;
        end else begin
            v_prio = rx_default_priority_i;
        end

        // receive verdict, all outputs are one-cycle pulses or held values
        next_cur.rx_done      = rx_valid_i;
        next_cur.rx_discard   = rx_valid_i && v_discard;
        next_cur.rx_mirror    = rx_valid_i && v_mirror;
        // the sniffer bitmap is passed as programmed, one port is expected
        next_cur.rx_sniffer   = cur.mirroring_control[MIR_SNIFF_LSB +: 3];
        next_cur.rx_learn     = rx_valid_i && v_learn;
        next_cur.rx_tag_dest  = rx_valid_i && v_tag_dest;
        next_cur.filtered_inc = 3'h0;
        if (rx_valid_i) begin
            next_cur.rx_queue = field2(cur.priority_queue_map, v_prio);
            // filtered frames count even when they also go to the sniffer
            if (v_discard && rx_port_i != 2'h3) begin
                next_cur.filtered_inc[rx_port_i] = 1'b1;
            end
        end

        // transmit mirroring copies to the sniffer
        next_cur.tx_mirror  = irq_event[IRQ_TX_MIR];
        next_cur.tx_sniffer = cur.mirroring_control[MIR_SNIFF_LSB +: 3];
    end

    // register all state; configuration takes its reset values here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur                              <= '0;
            cur.bus                          <= BUS_IDLE;
            cur.per_port_ingress_config      <= RST_PORT;
            cur.priority_queue_map           <= RST_PRIQ;
            cur.global_ingress_config        <= RST_ZERO;
            cur.admit_tagged_only            <= RST_ZERO;
            cur.spanning_tree_state          <= RST_ZERO;
            cur.mirroring_control            <= RST_ZERO;
            cur.ingress_tag_destination_type <= RST_ZERO;
            cur.irq_mask                     <= RST_ZERO;
        end else begin
            cur <= next_cur;
        end
    end

    // outputs straight from flops
    assign dat_o          = cur.rdat;
    assign ack_o          = cur.ack;
    assign rx_done_o      = cur.rx_done;
    assign rx_discard_o   = cur.rx_discard;
    assign rx_mirror_o    = cur.rx_mirror;
    assign rx_sniffer_o   = cur.rx_sniffer;
    assign rx_queue_o     = cur.rx_queue;
    assign rx_learn_o     = cur.rx_learn;
    assign rx_tag_dest_o  = cur.rx_tag_dest;
    assign filtered_inc_o = cur.filtered_inc;
    assign tx_mirror_o    = cur.tx_mirror;
    assign tx_sniffer_o   = cur.tx_sniffer;
    assign irq_o          = irq_line;
endmodule

// ### tb/swe_cfg_sva.sv
`timescale 1ns/1ps
module swe_cfg_sva (
    // clock and reset
    input wire logic       clk_i,
    input wire logic       rst_i,
    // bus answer
    input wire logic       ack_o,
    // frame strobes
    input wire logic       rx_valid_i,
    input wire logic [1:0] rx_port_i,
    input wire logic       rx_rule_drop_i,
    input wire logic       tx_valid_i,
    input wire logic [1:0] tx_port_i,
    // verdict
    input wire logic       rx_done_o,
    input wire logic       rx_discard_o,
    input wire logic       rx_mirror_o,
    input wire logic [2:0] filtered_inc_o,
    input wire logic [1:0] rx_queue_o,
    input wire logic       tx_mirror_o,
    input wire logic [2:0] rx_sniffer_o,
    input wire logic [2:0] tx_sniffer_o
);
    // one clock domain, so one clocking and one disable for all
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_one_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    a_done_after_rx: assert property (rx_valid_i |=> rx_done_o) else $error("no verdict");
    a_done_needs_rx: assert property (!rx_valid_i |=> !rx_done_o) else $error("stray verdict");
    a_drop_counts: assert property (rx_valid_i && rx_rule_drop_i && rx_port_i != 2'h3 |=>
        rx_discard_o && filtered_inc_o == 3'h1 << $past(rx_port_i)) else $error("drop not counted");
    a_inc_only_drop: assert property (filtered_inc_o != 3'h0 |->
        rx_discard_o && $onehot(filtered_inc_o)) else $error("bad filtered count");
    a_mirror_in_done: assert property (rx_mirror_o |-> rx_done_o) else $error("stray mirror");
    a_tx_mirror_src: assert property (tx_mirror_o |-> $past(tx_valid_i)) else $error("stray tx copy");
    a_sniffer_pair: assert property (rx_sniffer_o == tx_sniffer_o) else $error("sniffer differs");
    a_queue_hold: assert property (!rx_valid_i |=> $stable(rx_queue_o)) else $error("queue moved");
    c_drop_mirror: cover property (rx_discard_o && rx_mirror_o);
    c_tx_copy: cover property (tx_mirror_o);
    c_drop_count: cover property (filtered_inc_o != 3'h0);
endmodule
bind switch_ingress_mirror_config swe_cfg_sva swe_cfg_sva_inst (.clk_i(clk_i), .rst_i(rst_i),
    .ack_o(ack_o), .rx_valid_i(rx_valid_i), .rx_port_i(rx_port_i),
    .rx_rule_drop_i(rx_rule_drop_i), .tx_valid_i(tx_valid_i), .tx_port_i(tx_port_i),
    .rx_done_o(rx_done_o), .rx_discard_o(rx_discard_o), .rx_mirror_o(rx_mirror_o),
    .filtered_inc_o(filtered_inc_o), .rx_queue_o(rx_queue_o), .tx_mirror_o(tx_mirror_o),
    .rx_sniffer_o(rx_sniffer_o), .tx_sniffer_o(tx_sniffer_o));

// ### tb/switch_ingress_mirror_config_test.sv
`timescale 1ns/1ps
module switch_ingress_mirror_config_test;
    import swe_cfg_pkg::*;
    // driven inputs, valued at time zero
    logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0, tx_valid_i = 1'h0;
    logic rx_valid_i = 1'h0, rx_tagged_i = 1'h0, rx_prio_tagged_i = 1'h0, rx_rule_drop_i = 1'h0;
    logic [15:0] adr_i = 16'h0;
    logic [3:0]  sel_i = 4'hF; // full words only
    logic [31:0] dat_i = 32'h0, dat_o, q;
    logic [1:0]  rx_port_i = 2'h0, tx_port_i = 2'h0, rx_queue_o;
    logic [2:0]  rx_tag_priority_i = 3'h0, rx_default_priority_i = 3'h0;
    // observed outputs
    logic ack_o, rx_done_o, rx_discard_o, rx_mirror_o, rx_learn_o, rx_tag_dest_o, tx_mirror_o, irq_o;
    logic [2:0]  rx_sniffer_o, tx_sniffer_o, filtered_inc_o;
    int n_mismatch = 0, total_checks = 0, cycles = 0;
    // index, reset value, read-back after all ones; last entry is unmapped
    logic [13:0] ix [10] = '{IDX_GLOBAL_INGRESS, IDX_PORT_INGRESS, IDX_ADMIT_TAGGED, IDX_STP_STATE,
        IDX_PRI_QUEUE, IDX_MIRROR, IDX_TAG_DEST, IDX_IRQ_STATUS, IDX_IRQ_MASK, 14'h1844};
    logic [31:0] rv [10] = '{32'h0, 32'h38, 32'h0, 32'h0, 32'hFA41, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [31:0] wm [10] = '{32'h1, 32'h3F, 32'h7, 32'h3F, 32'hFFFF, 32'h1FF, 32'h3F, 32'h0, 32'h7, 32'h0};
    switch_ingress_mirror_config switch_ingress_mirror_config_inst (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .rx_valid_i(rx_valid_i), .rx_port_i(rx_port_i),
        .rx_tagged_i(rx_tagged_i), .rx_prio_tagged_i(rx_prio_tagged_i),
        .rx_rule_drop_i(rx_rule_drop_i), .rx_tag_priority_i(rx_tag_priority_i),
        .rx_default_priority_i(rx_default_priority_i), .tx_valid_i(tx_valid_i),
        .tx_port_i(tx_port_i), .rx_done_o(rx_done_o), .rx_discard_o(rx_discard_o),
        .rx_mirror_o(rx_mirror_o), .rx_sniffer_o(rx_sniffer_o), .rx_queue_o(rx_queue_o),
        .rx_learn_o(rx_learn_o), .rx_tag_dest_o(rx_tag_dest_o), .filtered_inc_o(filtered_inc_o),
        .tx_mirror_o(tx_mirror_o), .tx_sniffer_o(tx_sniffer_o), .irq_o(irq_o));
    always #2 clk_i = ~clk_i;
    // hang guard, the run needs a few hundred cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one classic cycle, held until ack is sampled; read data lands in q
    task automatic wb(input logic w, input logic [13:0] i, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= w;
        adr_i <= {i, 2'h0};
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'h1);
        q = dat_o;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
    endtask
    task automatic rd(input logic [13:0] i, input logic [31:0] e);
        wb(1'h0, i, 32'h0);
        chk(q, e);
    endtask
    // one-cycle frame strobe; returns at the edge where the verdict is sampled
    task automatic rx(input int p, input logic t, input logic pt, input logic dr, input int pr);
        @(posedge clk_i);
        rx_valid_i <= 1'h1;
        rx_port_i <= 2'(p);
        rx_tagged_i <= t;
        rx_prio_tagged_i <= pt;
        rx_rule_drop_i <= dr;
        rx_tag_priority_i <= 3'(pr);
        rx_default_priority_i <= ~3'(pr); // differs, so the priority source shows
        @(posedge clk_i);
        rx_valid_i <= 1'h0;
        @(posedge clk_i);
    endtask
    task automatic t_regs();
        for (int k = 0; k < 10; k++) rd(ix[k], rv[k]);
        for (int k = 0; k < 10; k++) begin
            wb(1'h1, ix[k], 32'hFFFF_FFFF);
            rd(ix[k], wm[k]);
        end
        $display("register test done");
    endtask
    task automatic t_admit();
        wb(1'h1, IDX_STP_STATE, 32'h0);
        wb(1'h1, IDX_MIRROR, 32'h0);
        wb(1'h1, IDX_ADMIT_TAGGED, 32'h5);
        wb(1'h1, IDX_GLOBAL_INGRESS, 32'h0);
        rx(0, 1'h0, 1'h0, 1'h0, 0);
        chk(rx_discard_o, 32'h0);
        wb(1'h1, IDX_GLOBAL_INGRESS, 32'h1);
        for (int p = 0; p < 3; p++) begin
            rx(p, 1'h0, 1'h0, 1'h0, 0);
            chk(rx_discard_o, p != 1);
            chk(filtered_inc_o, p == 1 ? 0 : 1 << p);
            rx(p, 1'h1, 1'h1, 1'h0, 0);
            chk(rx_discard_o, p != 1);
            rx(p, 1'h1, 1'h0, 1'h0, 0);
            chk(rx_discard_o, 32'h0);
        end
        $display("admit test done");
    endtask
    // spanning tree codes on port 1, ingress type codes on port 2
    task automatic t_state();
        wb(1'h1, IDX_ADMIT_TAGGED, 32'h0);
        for (int c = 0; c < 4; c++) begin
            wb(1'h1, IDX_STP_STATE, c << 2);
            wb(1'h1, IDX_TAG_DEST, c << 4);
            rx(1, 1'h1, 1'h0, 1'h0, 0);
            chk(rx_discard_o, c != 0);
            chk(rx_learn_o, c == 0 || c == 2);
            rx(2, 1'h1, 1'h0, 1'h0, 0);
            chk(rx_tag_dest_o, c == 3);
        end
        $display("state test done");
    endtask
    task automatic t_queue();
        wb(1'h1, IDX_STP_STATE, 32'h0);
        wb(1'h1, IDX_PRI_QUEUE, 32'h1B1B);
        for (int v = 1; v >= 0; v--) begin
            wb(1'h1, IDX_GLOBAL_INGRESS, v);
            for (int p = 0; p < 8; p++) begin
                rx(0, 1'h1, 1'h0, 1'h0, p);
                chk(rx_queue_o, 3 - ((v ? p : 7 - p) % 4));
            end
        end
        $display("queue test done");
    endtask
    task automatic t_mirror();
        wb(1'h1, IDX_MIRROR, 32'h57);
        for (int p = 0; p < 3; p++) begin
            rx(p, 1'h1, 1'h0, 1'h0, 0);
            chk(rx_mirror_o, p != 1);
            @(posedge clk_i);
            tx_valid_i <= 1'h1;
            tx_port_i <= 2'(p);
            @(posedge clk_i);
            tx_valid_i <= 1'h0;
            @(posedge clk_i);
            chk(tx_mirror_o, p != 1);
        end
        chk(rx_sniffer_o, 32'h2);
        rx(0, 1'h1, 1'h0, 1'h1, 0);
        chk({rx_discard_o, rx_mirror_o}, 32'h2);
        wb(1'h1, IDX_MIRROR, 32'h157);
        rx(2, 1'h1, 1'h0, 1'h1, 0);
        chk({rx_discard_o, rx_mirror_o, filtered_inc_o}, 32'h1C);
        wb(1'h1, IDX_MIRROR, 32'h55);
        rx(0, 1'h1, 1'h0, 1'h0, 0);
        chk(rx_mirror_o, 32'h0);
        $display("mirror test done");
    endtask
    // drop event raised masked, unmasked, then cleared by writing one
    task automatic t_irq();
        wb(1'h1, IDX_IRQ_MASK, 32'h0);
        wb(1'h1, IDX_IRQ_STATUS, 32'h7);
        rx(1, 1'h1, 1'h0, 1'h1, 0);
        chk(irq_o, 32'h0);
        rd(IDX_IRQ_STATUS, 32'h1);
        wb(1'h1, IDX_IRQ_MASK, 32'h1);
        @(posedge clk_i);
        chk(irq_o, 32'h1);
        wb(1'h1, IDX_IRQ_STATUS, 32'h1);
        @(posedge clk_i);
        chk(irq_o, 32'h0);
        $display("interrupt test done");
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'h0;
        t_regs();
        t_admit();
        t_state();
        t_queue();
        t_mirror();
        t_irq();
        finish_test();
    end
endmodule
